// ===== rtl/rvq_defs.vh
// constants for the receive video qualify and truncate block
// assumes inclusion by every design file of the block that uses its macros, before use
`ifndef RVQ_DEFS_VH
`define RVQ_DEFS_VH

// =====================================================================
// stream word layout
`define RVQ_DATA_W      8
`define RVQ_KIND_W      2
`define RVQ_WORD_W      10

// token kinds carried beside each byte
`define RVQ_K_DATA      2'h0
`define RVQ_K_FS        2'h1
`define RVQ_K_FE        2'h2
`define RVQ_K_LE        2'h3

// =====================================================================
// forwarding buffer
`define RVQ_FIFO_DEPTH  16
`define RVQ_FIFO_AW     4

// =====================================================================
// measurement and counter widths, reset values
`define RVQ_LEN_W       16
`define RVQ_LINES_W     16
`define RVQ_CNT_W       2
`define RVQ_CNT_MAX     2'h3
`define RVQ_CNT_RST     2'h0
`define RVQ_LEN_ONE     16'h0001
`define RVQ_LEN_ZERO    16'h0000

`endif

// ===== rtl/rvq_fifo.v
// forwarding buffer between the qualify logic and the video buffers
// assumes one clock; push and pop follow valid and ready
`timescale 1ns/1ns
module rvq_fifo #(
  parameter WIDTH = 10,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             core_clk,
  input  wire             rst_n,
  input  wire             in_valid,
  input  wire [WIDTH-1:0] in_word,
  output wire             in_ready,
  output wire             out_valid,
  output wire [WIDTH-1:0] out_word,
  input  wire             out_ready
);

  // ===================================================================
  // storage and pointers
  reg  [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg  [AW-1:0]    wr_ptr_q;
  reg  [AW-1:0]    rd_ptr_q;
  reg  [AW:0]      cnt_q;
  reg  [WIDTH-1:0] head_q;
  reg              head_vld_q;
  reg              ready_q;

  wire             push     = in_valid & ready_q;
  wire             free     = ~head_vld_q | out_ready;
  wire             take_mem = free & (cnt_q != {(AW+1){1'b0}});
  wire             bypass   = free & (cnt_q == {(AW+1){1'b0}}) & push;
  wire             wr_mem   = push & ~bypass;
  wire [AW:0]      cnt_d    = cnt_q + {{AW{1'b0}}, wr_mem} - {{AW{1'b0}}, take_mem};

  assign in_ready  = ready_q;
  assign out_valid = head_vld_q;
  assign out_word  = head_q;

  // ===================================================================
  // per entry write
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi = gi + 1) begin : g_ent
      always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          mem_q[gi] <= {WIDTH{1'b0}};
        end else if (wr_mem && (wr_ptr_q == gi)) begin
          mem_q[gi] <= in_word;
        end
      end
    end
  endgenerate

  // ===================================================================
  // pointers, head register, registered ready
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q   <= {AW{1'b0}};
      rd_ptr_q   <= {AW{1'b0}};
      cnt_q      <= {(AW+1){1'b0}};
      head_q     <= {WIDTH{1'b0}};
      head_vld_q <= 1'b0;
      ready_q    <= 1'b0;
    end else begin
      if (wr_mem) begin
        wr_ptr_q <= wr_ptr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (take_mem) begin
        rd_ptr_q <= rd_ptr_q + {{(AW-1){1'b0}}, 1'b1};
        head_q   <= mem_q[rd_ptr_q];
      end else if (bypass) begin
        head_q <= in_word;
      end
      if (free) begin
        head_vld_q <= take_mem | bypass;
      end
      cnt_q   <= cnt_d;
      // ready only when a slot is certain next cycle
      ready_q <= (cnt_d != DEPTH);
    end
  end

endmodule

// ===== rtl/rvq_qualify.v
// receive port video qualification, discard and frame truncation
// assumes a token stream from the serial receiver, one token a cycle,
// and configuration inputs held steady between frames
//
// How it works
// R1 - error in frame stops that frame's forwarding
// R2 - resume only at next frame start token
// R3 - downstream treats repeated start as suspect
// R4 - discard enabled: drop everything until pass
// R5 - truncate on size mismatch or csi parity
// R6 - size truncated frame gets no frame end
// R7 - truncation may hit any line, even first
// R8 - no resume mid frame after truncation
// R9 - frame count threshold zero to three
// R10 - threshold zero: pass follows link lock
// R11 - nonzero threshold: count valid frames first
// R12 - parity error frame still counts once
// R13 - software uses threshold two with parity
// R14 - line length must stay constant
// R15 - line length change restarts valid count
// R16 - line count change restarts valid count
// R17 - link parity error drops pass at once
// R18 - link parity error clears valid count
// R19 - lock loss drops pass, clears count
`timescale 1ns/1ns
`include "rvq_defs.vh"
module rvq_qualify (
  input  wire                   core_clk,
  input  wire                   rst_n,
  input  wire                   link_locked,
  input  wire                   link_parity_err,
  input  wire                   csi_parity_err,
  input  wire [`RVQ_CNT_W-1:0]  qualify_frame_count,
  input  wire                   discard_en,
  input  wire                   qualify_line_size,
  input  wire                   qualify_line_count,
  input  wire                   qualify_parity,
  input  wire                   trunc_line_size,
  input  wire                   trunc_line_count,
  input  wire                   trunc_csi_parity,
  input  wire                   in_valid,
  input  wire [`RVQ_KIND_W-1:0] in_kind,
  input  wire [`RVQ_DATA_W-1:0] in_data,
  output wire                   in_ready,
  output wire                   out_valid,
  output wire [`RVQ_KIND_W-1:0] out_kind,
  output wire [`RVQ_DATA_W-1:0] out_data,
  input  wire                   out_ready,
  output wire                   pass,
  output wire [`RVQ_CNT_W-1:0]  valid_frames,
  output wire                   line_len_chg,
  output wire                   line_cnt_chg,
  output wire                   frame_truncated,
  output wire                   forwarding
);

  // ===================================================================
  // state
  reg                    in_frame_q;
  reg                    fwd_q;
  reg                    bad_q;
  reg [`RVQ_LEN_W-1:0]   cur_len_q;
  reg [`RVQ_LEN_W-1:0]   ref_len_q;
  reg                    ref_len_ok_q;
  reg [`RVQ_LINES_W-1:0] lines_q;
  reg [`RVQ_LINES_W-1:0] ref_lines_q;
  reg                    ref_lines_ok_q;
  reg [`RVQ_CNT_W-1:0]   vcnt_q;
  reg                    pass_q;
  reg                    len_chg_q;
  reg                    cnt_chg_q;
  reg                    trunc_q;

  // ===================================================================
  // token decode
  wire                   acc;
  wire                   k_data;
  wire                   k_fs;
  wire                   k_fe;
  wire                   k_le;
  wire                   fifo_ready;

  assign acc    = in_valid & fifo_ready;
  assign k_data = acc & (in_kind == `RVQ_K_DATA);
  assign k_fs   = acc & (in_kind == `RVQ_K_FS);
  assign k_fe   = acc & (in_kind == `RVQ_K_FE);
  assign k_le   = acc & (in_kind == `RVQ_K_LE);

  // ===================================================================
  // size measurement checks
  reg                    len_err;
  reg                    cnt_err;
  reg                    par_hit;
  reg                    restart;
  reg                    trunc_now;
  reg                    allow_new;
  reg                    gate_off;
  reg                    fwd_tok;
  reg                    frame_good;
  reg [`RVQ_CNT_W-1:0]   vcnt_d;
  reg                    pass_d;

  always @* begin
    // over length seen on the extra byte, short length at line end
    len_err = in_frame_q & ref_len_ok_q &
              ((k_data & (cur_len_q == ref_len_q)) |
               (k_le & (cur_len_q != ref_len_q))); // R14
    // extra line seen on its first byte, short frame at frame end
    cnt_err = in_frame_q & ref_lines_ok_q &
              ((k_data & (cur_len_q == `RVQ_LEN_ZERO) & (lines_q == ref_lines_q)) |
               (k_fe & (lines_q != ref_lines_q))); // R16
    par_hit = qualify_parity & link_parity_err;
    restart = (qualify_line_size & len_err) | // R15
              (qualify_line_count & cnt_err) | // R16
              par_hit | // R18
              ~link_locked; // R19
    // parity hits do not mark the frame bad, so it counts once
    frame_good = ~bad_q & ~(qualify_line_size & len_err) &
                 ~(qualify_line_count & cnt_err); // R12 R14
    vcnt_d = vcnt_q;
    if (restart) begin
      vcnt_d = `RVQ_CNT_RST; // R15 R16 R18 R19
    end else if (k_fe && in_frame_q && frame_good) begin
      if (vcnt_q != `RVQ_CNT_MAX) begin
        vcnt_d = vcnt_q + 2'h1; // R11
      end
    end
    if (!link_locked || par_hit) begin
      pass_d = 1'b0; // R17 R19
    end else if (qualify_frame_count == `RVQ_CNT_RST) begin
      pass_d = 1'b1; // R10
    end else begin
      pass_d = (vcnt_d >= qualify_frame_count); // R9 R11
    end
  end

  // ===================================================================
  // forwarding decision
  always @* begin
    gate_off  = discard_en & ~pass_q; // R4
    allow_new = link_locked & ~gate_off;
    // a start token closes the old frame anyway and must not cut the new one
    trunc_now = in_frame_q & fwd_q & ~k_fs &
                ((trunc_line_size & len_err) |
                 (trunc_line_count & cnt_err) |
                 (trunc_csi_parity & csi_parity_err)); // R1 R5 R7
    fwd_tok = 1'b0;
    if (k_fs) begin
      fwd_tok = allow_new; // R2
    end else if (in_frame_q && fwd_q && !trunc_now && !gate_off && link_locked) begin
      // a truncated frame never sends its end token
      fwd_tok = 1'b1; // R6 R8
    end
  end

  // ===================================================================
  // frame and line tracking
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      in_frame_q     <= 1'b0;
      fwd_q          <= 1'b0;
      bad_q          <= 1'b0;
      cur_len_q      <= `RVQ_LEN_ZERO;
      ref_len_q      <= `RVQ_LEN_ZERO;
      ref_len_ok_q   <= 1'b0;
      lines_q        <= `RVQ_LEN_ZERO;
      ref_lines_q    <= `RVQ_LEN_ZERO;
      ref_lines_ok_q <= 1'b0;
    end else begin
      if (k_fs) begin
        // a repeated start without an end simply opens a new frame
        in_frame_q <= 1'b1;
        fwd_q      <= allow_new; // R2 R8
        bad_q      <= 1'b0;
        cur_len_q  <= `RVQ_LEN_ZERO;
        lines_q    <= `RVQ_LEN_ZERO;
      end else if (in_frame_q) begin
        if (trunc_now || gate_off || !link_locked) begin
          fwd_q <= 1'b0; // R1 R4 R8
        end
        if ((qualify_line_size && len_err) || (qualify_line_count && cnt_err)) begin
          bad_q <= 1'b1;
        end
        if (k_data) begin
          cur_len_q <= cur_len_q + `RVQ_LEN_ONE; // R14
        end
        if (k_le) begin
          ref_len_q    <= cur_len_q;
          ref_len_ok_q <= 1'b1;
          cur_len_q    <= `RVQ_LEN_ZERO;
          lines_q      <= lines_q + `RVQ_LEN_ONE;
        end
        if (k_fe) begin
          in_frame_q     <= 1'b0;
          fwd_q          <= 1'b0;
          ref_lines_q    <= lines_q;
          ref_lines_ok_q <= 1'b1;
        end
      end
      if (!link_locked) begin
        // a new lock may bring a new format, relearn the sizes
        in_frame_q     <= 1'b0;
        ref_len_ok_q   <= 1'b0;
        ref_lines_ok_q <= 1'b0;
      end
    end
  end

  // ===================================================================
  // qualification counter, pass and status pulses
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      vcnt_q    <= `RVQ_CNT_RST;
      pass_q    <= 1'b0;
      len_chg_q <= 1'b0;
      cnt_chg_q <= 1'b0;
      trunc_q   <= 1'b0;
    end else begin
      vcnt_q    <= vcnt_d;
      pass_q    <= pass_d;
      len_chg_q <= len_err;
      cnt_chg_q <= cnt_err;
      trunc_q   <= trunc_now;
    end
  end

  assign pass            = pass_q;
  assign valid_frames    = vcnt_q;
  assign line_len_chg    = len_chg_q;
  assign line_cnt_chg    = cnt_chg_q;
  assign frame_truncated = trunc_q;
  assign forwarding      = fwd_q;

  // ===================================================================
  // forwarding buffer; its ready stalls the receiver directly
  wire [`RVQ_WORD_W-1:0] head_word;

  rvq_fifo #(
    .WIDTH (`RVQ_WORD_W),
    .DEPTH (`RVQ_FIFO_DEPTH),
    .AW    (`RVQ_FIFO_AW)
  ) u_fifo (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .in_valid  (acc & fwd_tok),
    .in_word   ({in_kind, in_data}),
    .in_ready  (fifo_ready),
    .out_valid (out_valid),
    .out_word  (head_word),
    .out_ready (out_ready)
  );

  assign in_ready = fifo_ready;
  assign out_kind = head_word[`RVQ_WORD_W-1:`RVQ_DATA_W];
  assign out_data = head_word[`RVQ_DATA_W-1:0];

endmodule

// ===== testbench/rvq_monitor.sv
// assertions on the ports of the receive qualify and truncate block
// assumes a bind onto rvq_qualify, one clock domain, async active-low reset
`timescale 1ns/1ns
`include "rvq_defs.vh"
module rvq_monitor (
  input logic                  core_clk,
  input logic                  rst_n,
  input logic                  link_locked,
  input logic                  link_parity_err,
  input logic [`RVQ_CNT_W-1:0] qualify_frame_count,
  input logic                  discard_en,
  input logic                  qualify_line_size,
  input logic                  qualify_line_count,
  input logic                  qualify_parity,
  input logic                  pass,
  input logic [`RVQ_CNT_W-1:0] valid_frames,
  input logic                  line_len_chg,
  input logic                  line_cnt_chg,
  input logic                  frame_truncated,
  input logic                  forwarding
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // =====================================================
  // restart causes
  sequence s_lock_drop;
    link_locked ##1 !link_locked;
  endsequence
  sequence s_parity_hit;
    qualify_parity && link_parity_err;
  endsequence
  // =====================================================
  // checks
  chk_trunc_stops_fwd: assert property (frame_truncated |-> !forwarding)
    else $error("forwarding still set after truncation");
  chk_lock_loss_clear: assert property (s_lock_drop |=> !pass && valid_frames == 2'h0)
    else $error("lock loss did not clear pass and count");
  chk_parity_drops: assert property (s_parity_hit |=> !pass && valid_frames == 2'h0)
    else $error("link parity error did not clear pass and count");
  chk_thr_zero_pass: assert property ((qualify_frame_count == 2'h0 && link_locked
    && !(qualify_parity && link_parity_err)) |=> pass)
    else $error("pass missing with zero threshold and lock");
  chk_pass_has_count: assert property ((pass && qualify_frame_count != 2'h0)
    |-> valid_frames >= qualify_frame_count)
    else $error("pass raised below the frame threshold");
  chk_count_steps: assert property ((valid_frames != $past(valid_frames))
    |-> (valid_frames == 2'h0 || valid_frames == $past(valid_frames) + 2'h1))
    else $error("valid frame count jumped");
  chk_len_restart: assert property (qualify_line_size && line_len_chg |-> valid_frames == 2'h0)
    else $error("length change kept the count");
  chk_cnt_restart: assert property (qualify_line_count && line_cnt_chg |-> valid_frames == 2'h0)
    else $error("line count change kept the count");
  chk_discard_stop: assert property (discard_en && !pass |-> ##[1:2] !forwarding)
    else $error("forwarding while discarding");
endmodule
bind rvq_qualify rvq_monitor i_rvq_monitor (
  .core_clk(core_clk), .rst_n(rst_n), .link_locked(link_locked),
  .link_parity_err(link_parity_err), .qualify_frame_count(qualify_frame_count),
  .discard_en(discard_en), .qualify_line_size(qualify_line_size),
  .qualify_line_count(qualify_line_count), .qualify_parity(qualify_parity), .pass(pass),
  .valid_frames(valid_frames), .line_len_chg(line_len_chg), .line_cnt_chg(line_cnt_chg),
  .frame_truncated(frame_truncated), .forwarding(forwarding));

// ===== testbench/rvq_sink.sv
// downstream video buffer model taking the forwarded token stream
// assumes the token kinds of rvq_defs.vh and one clock
`timescale 1ns/1ns
`include "rvq_defs.vh"
module rvq_sink (
  input  logic                   core_clk,
  input  logic                   stall,
  input  logic                   out_valid,
  input  logic [`RVQ_KIND_W-1:0] out_kind,
  output logic                   out_ready,
  output int                     fe_cnt,
  output int                     byte_cnt,
  output int                     suspect_cnt
);
  logic open_q;
  initial begin
    out_ready = 1'b0;
    open_q = 1'b0;
    fe_cnt = 0;
    byte_cnt = 0;
    suspect_cnt = 0;
  end
  always @(posedge core_clk) begin
    out_ready <= #1 !stall;
    if (out_valid && out_ready) begin
      if (out_kind == `RVQ_K_FS) begin
        // a start inside an open frame marks its data as suspect
        if (open_q) suspect_cnt <= suspect_cnt + 1;
        open_q <= 1'b1;
      end
      if (out_kind == `RVQ_K_FE) begin
        fe_cnt <= fe_cnt + 1;
        open_q <= 1'b0;
      end
      if (out_kind == `RVQ_K_DATA) byte_cnt <= byte_cnt + 1;
    end
  end
endmodule

// ===== testbench/rvq_qualify_tb.sv
// self-checking bench for the receive qualify and truncate block
// assumes rvq_qualify, its monitor and the sink model compiled before
`timescale 1ns/1ns
`include "rvq_defs.vh"
module rvq_qualify_tb;
  typedef struct packed {logic [1:0] thr; logic [2:0] frames; logic pass; logic [1:0] fe;} rvq_row_t;
  logic       core_clk, rst_n, link_locked, link_parity_err, csi_parity_err, discard_en;
  logic       qualify_line_size, qualify_line_count, qualify_parity, in_valid, stall;
  logic       trunc_line_size, trunc_line_count, trunc_csi_parity;
  logic       saw_trunc, saw_len, saw_cnt, saw_full;
  logic [1:0] qualify_frame_count, in_kind;
  logic [7:0] in_data, last_byte;
  wire        in_ready, out_valid, out_ready, pass, line_len_chg, line_cnt_chg;
  wire        frame_truncated, forwarding;
  wire  [1:0] out_kind, valid_frames;
  wire  [7:0] out_data;
  int         fe_cnt, byte_cnt, suspect_cnt, errors, comparisons, fe0, nb0;
  // lines, last line length, error bits, last data byte that reaches the sink
  int         bad [4][4] = '{'{2, 4, 0, 18}, '{1, 2, 0, 1}, '{3, 3, 0, 18}, '{2, 3, 1, 18}};
  // fe 2'h3 means the forwarded count is not judged
  rvq_row_t   rows [7] = '{'{2'h0, 3'h1, 1'h1, 2'h1}, '{2'h1, 3'h0, 1'h0, 2'h0},
    '{2'h1, 3'h2, 1'h1, 2'h3}, '{2'h2, 3'h1, 1'h0, 2'h0}, '{2'h2, 3'h3, 1'h1, 2'h3},
    '{2'h3, 3'h2, 1'h0, 2'h0}, '{2'h3, 3'h4, 1'h1, 2'h3}};
  rvq_qualify i_rvq_qualify (.core_clk(core_clk), .rst_n(rst_n), .link_locked(link_locked),
    .link_parity_err(link_parity_err), .csi_parity_err(csi_parity_err),
    .qualify_frame_count(qualify_frame_count), .discard_en(discard_en),
    .qualify_line_size(qualify_line_size), .qualify_line_count(qualify_line_count),
    .qualify_parity(qualify_parity), .trunc_line_size(trunc_line_size),
    .trunc_line_count(trunc_line_count), .trunc_csi_parity(trunc_csi_parity),
    .in_valid(in_valid), .in_kind(in_kind), .in_data(in_data), .in_ready(in_ready),
    .out_valid(out_valid), .out_kind(out_kind), .out_data(out_data), .out_ready(out_ready),
    .pass(pass), .valid_frames(valid_frames), .line_len_chg(line_len_chg),
    .line_cnt_chg(line_cnt_chg), .frame_truncated(frame_truncated), .forwarding(forwarding));
  rvq_sink i_rvq_sink (.core_clk(core_clk), .stall(stall), .out_valid(out_valid),
    .out_kind(out_kind), .out_ready(out_ready), .fe_cnt(fe_cnt), .byte_cnt(byte_cnt),
    .suspect_cnt(suspect_cnt));
  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (frame_truncated) saw_trunc <= 1'b1;
    if (line_len_chg) saw_len <= 1'b1;
    if (line_cnt_chg) saw_cnt <= 1'b1;
    if (rst_n && !in_ready) saw_full <= 1'b1;
    if (out_valid && out_ready && out_kind == `RVQ_K_DATA) last_byte <= out_data;
  end
  // =====================================================
  // helpers
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask
  task tally_and_finish;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // token held until the edge that samples in_ready high
  task put(input logic [1:0] k, input logic [7:0] d);
    int n;
    n = 0;
    in_valid = 1'b1;
    in_kind = k;
    in_data = d;
    @(posedge core_clk);
    while (!in_ready && n < 200) begin
      n++;
      @(posedge core_clk);
    end
    // a token never taken counts against the run
    if (!in_ready) errors++;
    #1;
  endtask
  // last line has ll bytes, others 3; err bit0 csi, bit1 link parity
  task frame(input int nl, input int ll, input logic [1:0] err);
    put(`RVQ_K_FS, 8'h00);
    for (int i = 0; i < nl; i++) begin
      for (int b = 0; b < (i == nl - 1 ? ll : 3); b++) begin
        csi_parity_err = err[0] && i == 0 && b == 0;
        link_parity_err = err[1] && i == 0 && b == 0;
        put(`RVQ_K_DATA, 8'(b + 16 * i));
      end
      put(`RVQ_K_LE, 8'h00);
    end
    put(`RVQ_K_FE, 8'h00);
    in_valid = 1'b0;
    cyc(4);
  endtask
  // threshold only changes while unlocked, so pass is already low
  task relock(input logic [1:0] thr);
    link_locked = 1'b0;
    cyc(2);
    qualify_frame_count = thr;
    cyc(1);
    link_locked = 1'b1;
    cyc(3);
  endtask
  // =====================================================
  // sequence
  initial begin
    #200000;
    errors++;
    tally_and_finish();
  end
  initial begin
    {link_locked, link_parity_err, csi_parity_err, qualify_parity, in_valid, stall} = 6'h00;
    {saw_trunc, saw_len, saw_cnt, saw_full, in_kind, in_data, qualify_frame_count} = 16'h0000;
    {qualify_line_size, qualify_line_count, trunc_line_size, trunc_line_count} = 4'hf;
    trunc_csi_parity = 1'b1;
    discard_en = 1'b1;
    rst_n = 1'b0;
    repeat (6) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    cyc(2);
    chk(pass, 1'b0);
    chk(valid_frames, 2'h0);
    chk(out_valid, 1'b0);
    foreach (rows[r]) begin
      relock(rows[r].thr);
      fe0 = fe_cnt;
      repeat (rows[r].frames) frame(2, 3, 2'h0);
      cyc(4);
      chk(pass, rows[r].pass);
      if (rows[r].fe != 2'h3) chk(fe_cnt - fe0, rows[r].fe);
    end
    discard_en = 1'b0;
    foreach (bad[k]) begin
      relock(2'h1);
      frame(2, 3, 2'h0);
      fe0 = fe_cnt;
      saw_trunc = 1'b0;
      frame(bad[k][0], bad[k][1], 2'(bad[k][2]));
      chk(fe_cnt - fe0, 0);
      chk(saw_trunc, 1'b1);
      chk(last_byte, 8'(bad[k][3]));
      relock(2'h1);
      frame(2, 3, 2'h0);
      chk(fe_cnt - fe0, 1);
    end
    chk(saw_len, 1'b1);
    chk(saw_cnt, 1'b1);
    chk(suspect_cnt, 4);
    qualify_parity = 1'b1;
    relock(2'h2);
    repeat (3) frame(2, 3, 2'h0);
    chk(pass, 1'b1);
    frame(2, 3, 2'h2);
    chk(pass, 1'b0);
    chk(valid_frames, 2'h1);
    frame(2, 3, 2'h0);
    chk(pass, 1'b1);
    qualify_parity = 1'b0;
    relock(2'h0);
    nb0 = byte_cnt;
    saw_full = 1'b0;
    stall = 1'b1;
    fork
      frame(1, 20, 2'h0);
      begin
        cyc(40);
        stall = 1'b0;
      end
    join
    cyc(20);
    chk(saw_full, 1'b1);
    chk(byte_cnt - nb0, 20);
    tally_and_finish();
  end
endmodule
